// *** hw/tw_timer.sv ***
`include "tw_timer_defs.svh"
`default_nettype none
module tw_timer (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [15:0] bus_rdata,
  input  wire logic        capture_event,
  output logic             pin_a_out,
  output logic             pin_a_oe,
  output logic             pin_b_out,
  output logic             pin_b_oe,
  output logic             overflow_flag,
  output logic             compare_a_match_flag,
  output logic             compare_b_match_flag,
  output logic             capture_flag
);
  import tw_timer_pkg::*;

  logic [15:0] ctrl_reg;
  logic [3:0]  port_reg;
  logic [15:0] counter_value_reg;
  logic [15:0] cmp_buf_reg [2];
  logic [15:0] cmp_act_reg [2];
  logic [15:0] capture_register_reg;
  logic [1:0]  output_state_reg;
  logic [3:0]  flags_reg;
  logic [9:0]  presc_reg;
  logic        block_reg;
  logic [15:0] rdata_reg;
  logic [1:0]  pin_out_reg;
  logic [1:0]  pin_oe_reg;

  logic [3:0]  waveform_gen_mode;
  tw_clk_sel_t clk_sel;
  logic [1:0]  compare_output_mode [2];
  logic        is_pwm;
  logic        clears_at_top;
  logic        icr_is_top;
  logic [15:0] top_val;
  logic        tick;
  logic        top_hit;
  logic        wrap_hit;
  logic        ovf_set;
  logic [1:0]  match;
  logic [1:0]  output_state_next;
  logic [3:0]  flags_next;

  logic wr_ctrl;
  logic wr_force;
  logic wr_port;
  logic wr_count;
  logic wr_capt;
  logic wr_flags;

  assign wr_ctrl  = bus_wr && (bus_addr == `TW_ADDR_CTRL);
  assign wr_force = bus_wr && (bus_addr == `TW_ADDR_FORCE);
  assign wr_port  = bus_wr && (bus_addr == `TW_ADDR_PORT);
  assign wr_count = bus_wr && (bus_addr == `TW_ADDR_COUNT);
  assign wr_capt  = bus_wr && (bus_addr == `TW_ADDR_CAPTURE);
  assign wr_flags = bus_wr && (bus_addr == `TW_ADDR_FLAGS);

  assign waveform_gen_mode      = ctrl_reg[`TW_CTRL_WGM_LSB +: 4];
  assign clk_sel                = tw_clk_sel_t'(ctrl_reg[`TW_CTRL_CSEL_LSB +: 3]);
  assign compare_output_mode[0] = ctrl_reg[`TW_CTRL_COMA_LSB +: 2];
  assign compare_output_mode[1] = ctrl_reg[`TW_CTRL_COMB_LSB +: 2];

  // Only the waveform mode shapes the count; the output modes never enter here.
  always_comb
  begin
    is_pwm        = 1'b0;
    clears_at_top = 1'b1;
    icr_is_top    = 1'b0;
    top_val       = `TW_MAX;
    unique case (waveform_gen_mode)
      `TW_WGM_CTC_A:     top_val = cmp_act_reg[0];
      `TW_WGM_CTC_CAPT:
      begin
        top_val    = capture_register_reg;
        icr_is_top = 1'b1;
      end
      `TW_WGM_FPWM_8:
      begin
        top_val = `TW_TOP_8;
        is_pwm  = 1'b1;
      end
      `TW_WGM_FPWM_9:
      begin
        top_val = `TW_TOP_9;
        is_pwm  = 1'b1;
      end
      `TW_WGM_FPWM_10:
      begin
        top_val = `TW_TOP_10;
        is_pwm  = 1'b1;
      end
      `TW_WGM_FPWM_CAPT:
      begin
        top_val    = capture_register_reg;
        icr_is_top = 1'b1;
        is_pwm     = 1'b1;
      end
      `TW_WGM_FPWM_A:
      begin
        top_val = cmp_act_reg[0];
        is_pwm  = 1'b1;
      end
      // Normal mode and the dual-slope codes this block does not build run free.
      default:           clears_at_top = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || clk_sel == tw_clk_stop || tick)
      presc_reg <= 10'h000;
    else
      presc_reg <= presc_reg + 10'h001;
  end

  always_comb
  begin
    tick = 1'b0;
    unique case (clk_sel)
      tw_clk_div1:    tick = 1'b1;
      tw_clk_div8:    tick = (presc_reg == `TW_DIV_8_LAST);
      tw_clk_div64:   tick = (presc_reg == `TW_DIV_64_LAST);
      tw_clk_div256:  tick = (presc_reg == `TW_DIV_256_LAST);
      tw_clk_div1024: tick = (presc_reg == `TW_DIV_1024_LAST);
      default:        tick = 1'b0;
    endcase
  end

  // A TOP written below the count is simply not met until the wrap at MAX.
  assign top_hit  = tick && clears_at_top && (counter_value_reg == top_val);
  assign wrap_hit = tick && (counter_value_reg == `TW_MAX);
  assign ovf_set  = is_pwm ? top_hit : wrap_hit;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      counter_value_reg <= `TW_BOTTOM;
    else if (wr_count)
      counter_value_reg <= bus_wdata;
    else if (top_hit)
      counter_value_reg <= `TW_BOTTOM;
    else if (tick)
      counter_value_reg <= counter_value_reg + 16'h0001;
  end

  // A counter write hides any match on the next tick, even while stopped.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      block_reg <= 1'b0;
    else if (wr_count)
      block_reg <= 1'b1;
    else if (tick)
      block_reg <= 1'b0;
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
      match[i] = tick && !block_reg && (counter_value_reg == cmp_act_reg[i]);
  end

  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (sys_rst)
      begin
        cmp_buf_reg[i] <= `TW_BOTTOM;
        cmp_act_reg[i] <= `TW_BOTTOM;
      end
      else
      begin
        if (bus_wr && bus_addr == (`TW_ADDR_CMP_A + 4'(i)))
          cmp_buf_reg[i] <= bus_wdata;
        if (!is_pwm && bus_wr && bus_addr == (`TW_ADDR_CMP_A + 4'(i)))
          cmp_act_reg[i] <= bus_wdata;
        else if (is_pwm && top_hit)
          cmp_act_reg[i] <= cmp_buf_reg[i];
      end
    end
  end

  // Capture ignores the output modes entirely.
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      capture_register_reg <= `TW_BOTTOM;
    else if (wr_capt)
      capture_register_reg <= bus_wdata;
    else if (capture_event && !icr_is_top)
      capture_register_reg <= counter_value_reg;
  end

  function automatic tw_act_t match_act(input logic [1:0] com, input logic pwm,
                                        input logic toggle_ok);
    tw_act_t a;
    a = tw_act_none;
    if (!pwm)
      unique case (com)
        2'h1:    a = tw_act_toggle;
        2'h2:    a = tw_act_clear;
        2'h3:    a = tw_act_set;
        default: a = tw_act_none;
      endcase
    else
      unique case (com)
        2'h1:    a = toggle_ok ? tw_act_toggle : tw_act_none;
        2'h2:    a = tw_act_set;
        2'h3:    a = tw_act_clear;
        default: a = tw_act_none;
      endcase
    return a;
  endfunction

  function automatic logic apply_act(input logic st, input tw_act_t a);
    logic r;
    r = st;
    unique case (a)
      tw_act_clear:  r = 1'b0;
      tw_act_set:    r = 1'b1;
      tw_act_toggle: r = !st;
      default:       r = st;
    endcase
    return r;
  endfunction

  // The output mode is read live, so a new value counts from the next match on.
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      output_state_next[i] = output_state_reg[i];
      if (!is_pwm && wr_force && bus_wdata[i])
        output_state_next[i] = apply_act(output_state_reg[i],
          match_act(compare_output_mode[i], 1'b0, 1'b0));
      else
      begin
        if (is_pwm && top_hit && compare_output_mode[i][1])
          output_state_next[i] = compare_output_mode[i][0];
        // The match wins over TOP so a compare equal to TOP gives a steady level.
        if (match[i])
          output_state_next[i] = apply_act(output_state_next[i],
            match_act(compare_output_mode[i], is_pwm,
                      (i == 0) && (waveform_gen_mode == `TW_WGM_FPWM_A)));
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      output_state_reg <= 2'h0;
    else
      output_state_reg <= output_state_next;
  end

  // A set arriving with its write-one clear is kept.
  always_comb
  begin
    flags_next = flags_reg;
    if (wr_flags)
      flags_next = flags_reg & ~bus_wdata[3:0];
    if (ovf_set)
      flags_next[`TW_FLAG_OVF] = 1'b1;
    if (match[0])
      flags_next[`TW_FLAG_CMPA] = 1'b1;
    if (match[1])
      flags_next[`TW_FLAG_CMPB] = 1'b1;
    if ((icr_is_top && top_hit) || (capture_event && !icr_is_top))
      flags_next[`TW_FLAG_CAPT] = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      flags_reg <= 4'h0;
    else
      flags_reg <= flags_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg <= `TW_RST_CTRL;
      port_reg <= `TW_RST_PORT;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= bus_wdata;
      if (wr_port)
        port_reg <= bus_wdata[3:0];
    end
  end

  // The direction bit alone decides whether the pin is driven.
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (sys_rst)
      begin
        pin_out_reg[i] <= 1'b0;
        pin_oe_reg[i]  <= 1'b0;
      end
      else
      begin
        pin_out_reg[i] <= (compare_output_mode[i] != 2'h0) ? output_state_reg[i]
                                                             : port_reg[`TW_PORT_VAL_LSB + i];
        pin_oe_reg[i]  <= port_reg[`TW_PORT_DIR_LSB + i];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !bus_rd)
      rdata_reg <= 16'h0000;
    else
      unique case (bus_addr)
        `TW_ADDR_CTRL:    rdata_reg <= ctrl_reg;
        `TW_ADDR_PORT:    rdata_reg <= {10'h000, output_state_reg, port_reg};
        `TW_ADDR_COUNT:   rdata_reg <= counter_value_reg;
        `TW_ADDR_CMP_A:   rdata_reg <= cmp_buf_reg[0];
        `TW_ADDR_CMP_B:   rdata_reg <= cmp_buf_reg[1];
        `TW_ADDR_CAPTURE: rdata_reg <= capture_register_reg;
        `TW_ADDR_FLAGS:   rdata_reg <= {12'h000, flags_reg};
        default:          rdata_reg <= 16'h0000;
      endcase
  end

  assign bus_rdata            = rdata_reg;
  assign pin_a_out            = pin_out_reg[0];
  assign pin_a_oe             = pin_oe_reg[0];
  assign pin_b_out            = pin_out_reg[1];
  assign pin_b_oe             = pin_oe_reg[1];
  assign overflow_flag        = flags_reg[`TW_FLAG_OVF];
  assign compare_a_match_flag = flags_reg[`TW_FLAG_CMPA];
  assign compare_b_match_flag = flags_reg[`TW_FLAG_CMPB];
  assign capture_flag         = flags_reg[`TW_FLAG_CAPT];
endmodule
`default_nettype wire

// *** hw/tw_timer_defs.svh ***
`ifndef TW_TIMER_DEFS_SVH
`define TW_TIMER_DEFS_SVH

`define TW_ADDR_CTRL      4'h0
`define TW_ADDR_FORCE     4'h1
`define TW_ADDR_PORT      4'h2
`define TW_ADDR_COUNT     4'h3
`define TW_ADDR_CMP_A     4'h4
`define TW_ADDR_CMP_B     4'h5
`define TW_ADDR_CAPTURE   4'h6
`define TW_ADDR_FLAGS     4'h7

`define TW_CTRL_WGM_LSB   0
`define TW_CTRL_CSEL_LSB  4
`define TW_CTRL_COMA_LSB  8
`define TW_CTRL_COMB_LSB  10

`define TW_PORT_VAL_LSB   0
`define TW_PORT_DIR_LSB   2

`define TW_FLAG_OVF       0
`define TW_FLAG_CMPA      1
`define TW_FLAG_CMPB      2
`define TW_FLAG_CAPT      3

`define TW_WGM_NORMAL     4'h0
`define TW_WGM_CTC_A      4'h4
`define TW_WGM_FPWM_8     4'h5
`define TW_WGM_FPWM_9     4'h6
`define TW_WGM_FPWM_10    4'h7
`define TW_WGM_CTC_CAPT   4'hC
`define TW_WGM_FPWM_CAPT  4'hE
`define TW_WGM_FPWM_A     4'hF

`define TW_TOP_8          16'h00FF
`define TW_TOP_9          16'h01FF
`define TW_TOP_10         16'h03FF
`define TW_MAX            16'hFFFF
`define TW_BOTTOM         16'h0000

`define TW_DIV_8_LAST     10'h007
`define TW_DIV_64_LAST    10'h03F
`define TW_DIV_256_LAST   10'h0FF
`define TW_DIV_1024_LAST  10'h3FF

`define TW_RST_CTRL       16'h0000
`define TW_RST_PORT       4'h0

`endif

// *** hw/tw_timer_pkg.sv ***
`default_nettype none
package tw_timer_pkg;
  typedef enum logic [1:0] {tw_act_none, tw_act_clear, tw_act_set, tw_act_toggle} tw_act_t;
  typedef enum logic [2:0] {tw_clk_stop, tw_clk_div1, tw_clk_div8, tw_clk_div64,
                            tw_clk_div256, tw_clk_div1024, tw_clk_res6, tw_clk_res7} tw_clk_sel_t;
endpackage
`default_nettype wire

// *** verif/tw_pin_load.sv ***
`default_nettype none
module tw_pin_load (
  input  wire logic drive,
  input  wire logic enable,
  output logic      level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_reg = 1'b0;
  // The line has no pull, so once released it shows the opposite of its last level.
  always @(drive or enable)
    if (enable)
      last_reg = drive;
  assign level = enable ? drive : ~last_reg;
endmodule
`default_nettype wire

// *** verif/tw_timer_props.sv ***
`include "tw_timer_defs.svh"
`default_nettype none
module tw_timer_props (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe,
  input wire logic        overflow_flag,
  input wire logic        compare_a_match_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // A shadow of the control word lets mode checks work from the ports alone.
  logic      [15:0] ctrl_reg;
  wire logic [3:0]  mode     = ctrl_reg[3:0];
  wire logic        wr_port  = bus_wr && bus_addr == `TW_ADDR_PORT;
  wire logic        wr_flag  = bus_wr && bus_addr == `TW_ADDR_FLAGS;
  wire logic        clr_ovf  = wr_flag && bus_wdata[`TW_FLAG_OVF];
  wire logic        clr_cmpa = wr_flag && bus_wdata[`TW_FLAG_CMPA];
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      ctrl_reg <= 16'h0000;
    else if (bus_wr && bus_addr == `TW_ADDR_CTRL)
      ctrl_reg <= bus_wdata;
  end
  sequence ctc_match_s;
    $rose(compare_a_match_flag) && mode == `TW_WGM_CTC_A && ctrl_reg[9:8] == 2'h1;
  endsequence
  sequence port_direct_s;
    (wr_port && ctrl_reg[9:8] == 2'h0) ##1 (ctrl_reg[9:8] == 2'h0);
  endsequence
  sequence top_flag_s;
    $rose(overflow_flag) && $past(mode) == `TW_WGM_FPWM_A;
  endsequence
  chk_rst_outputs: assert property ($fell(sys_rst) |-> !pin_a_out && !pin_a_oe)
    else $error("pin outputs not cleared by reset");
  chk_rdata_idle: assert property (!bus_rd |=> bus_rdata == 16'h0000)
    else $error("read data present without a read");
  chk_dir_drive: assert property (wr_port
    |-> ##2 pin_a_oe == $past(bus_wdata[2], 2))
    else $error("pin enable does not follow direction bit");
  chk_port_value: assert property (port_direct_s
    |=> pin_a_out == $past(bus_wdata[0], 2))
    else $error("pin does not show port value with mode zero");
  chk_ovf_sticky: assert property (overflow_flag && !clr_ovf |=> overflow_flag)
    else $error("overflow flag dropped without a clear");
  chk_cmpa_clear: assert property ($fell(compare_a_match_flag)
    |-> $past(clr_cmpa))
    else $error("compare flag dropped without a clear");
  chk_ctc_toggle: assert property (ctc_match_s |=> $changed(pin_a_out))
    else $error("pin did not toggle on match");
  chk_top_flags: assert property (top_flag_s |-> compare_a_match_flag)
    else $error("compare flag missing at top");
endmodule
bind tw_timer tw_timer_props chk_u (.ref_clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr,
  .bus_rd, .bus_rdata, .pin_a_out, .pin_a_oe, .overflow_flag, .compare_a_match_flag);
`default_nettype wire

// *** verif/tw_timer_tb_top.sv ***
`include "tw_timer_defs.svh"
`default_nettype none
module tw_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CTL = `TW_ADDR_CTRL, FRC = `TW_ADDR_FORCE, PRT = `TW_ADDR_PORT;
  localparam logic [3:0] CNT = `TW_ADDR_COUNT, CMA = `TW_ADDR_CMP_A, CMB = `TW_ADDR_CMP_B;
  localparam logic [3:0] CAP = `TW_ADDR_CAPTURE, FLG = `TW_ADDR_FLAGS;
  localparam logic [3:0]  ZREG [6] = '{4'h0, 4'h2, 4'h3, 4'h7, 4'h9, 4'hF};
  localparam int          DIV [5] = '{1, 8, 64, 256, 1024};
  localparam logic [15:0] TCTL [5] = '{16'h0015, 16'h0016, 16'h0017, 16'h001E, 16'h001C};
  localparam logic [15:0] TTOP [5] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0040, 16'h0040};
  localparam int          TFLG [5] = '{0, 0, 0, 0, 3};
  logic            ref_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic     [3:0]  bus_addr = 4'h0;
  logic     [15:0] bus_wdata = 16'h0000;
  logic            bus_wr = 1'b0;
  logic            bus_rd = 1'b0;
  logic            capture_event = 1'b0;
  logic     [15:0] bus_rdata;
  logic            pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, level_a, level_b;
  wire logic [3:0] flags;
  logic     [15:0] rv;
  int              n, h;
  int              n_errors = 0;
  int              comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  tw_timer dut_u (.ref_clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .capture_event, .pin_a_out, .pin_a_oe, .pin_b_out, .pin_b_oe,
    .overflow_flag(flags[0]), .compare_a_match_flag(flags[1]),
    .compare_b_match_flag(flags[2]), .capture_flag(flags[3]));
  tw_pin_load load_a_u (.drive(pin_a_out), .enable(pin_a_oe), .level(level_a));
  tw_pin_load load_b_u (.drive(pin_b_out), .enable(pin_b_oe), .level(level_b));
  task automatic end_of_test();
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic halt();
    wr(CTL, 16'h0000);
    wr(CNT, 16'h0000);
    wr(FLG, 16'h000F);
  endtask
  // Every wait is bounded, so a dead counter ends the run instead of hanging it.
  task automatic wait_flag(input int idx, input int lim, output int cnt);
    cnt = 0;
    while (flags[idx] !== 1'b1)
    begin
      cycles(1);
      cnt++;
      if (cnt > lim)
      begin
        n_errors++;
        end_of_test();
      end
    end
  endtask
  task automatic high_count(input logic sel_b, input int len, output int hc);
    hc = 0;
    repeat (len)
    begin
      cycles(1);
      if ((sel_b ? level_b : level_a) === 1'b1)
        hc++;
    end
  endtask
  task automatic t_reset();
    foreach (ZREG[i])
    begin
      rd(ZREG[i], rv);
      check(rv, 16'h0000);
    end
    $display("t_reset done");
  endtask
  task automatic t_force();
    // Output mode 3 sets and mode 1 toggles outside PWM.
    wr(CTL, 16'h0300);
    wr(PRT, 16'h0004);
    wr(FRC, 16'h0001);
    cycles(2);
    check(16'(level_a), 16'h0001);
    wr(CTL, 16'h0100);
    wr(FRC, 16'h0001);
    cycles(2);
    check(16'(level_a), 16'h0000);
    wr(CTL, 16'h0000);
    wr(PRT, 16'h0005);
    wr(FRC, 16'h0001);
    cycles(2);
    check(16'(level_a), 16'h0001);
    rd(PRT, rv);
    check(rv, 16'h0005);
    // A set action would show here if the strobe were wrongly taken in PWM mode.
    wr(CTL, 16'h030F);
    wr(FRC, 16'h0001);
    cycles(2);
    check(16'(level_a), 16'h0000);
    $display("t_force done");
  endtask
  task automatic t_prescale();
    for (int i = 0; i < 5; i++)
    begin
      halt();
      wr(CTL, 16'((i + 1) << 4));
      cycles(2048);
      wr(CTL, 16'h0000);
      rd(CNT, rv);
      check(16'(rv - 16'(2048 / DIV[i]) <= 16'h0003), 16'h0001);
    end
    $display("t_prescale done");
  endtask
  task automatic t_normal();
    halt();
    wr(CNT, 16'hFFF0);
    wr(CTL, 16'h0010);
    wait_flag(0, 40, n);
    check(16'(n), 16'h0010);
    rd(CNT, rv);
    check(16'(rv < 16'h0008), 16'h0001);
    wr(CNT, 16'h8000);
    rd(CNT, rv);
    check(16'(rv - 16'h8000 <= 16'h0004), 16'h0001);
    halt();
    rd(FLG, rv);
    check(rv, 16'h0000);
    $display("t_normal done");
  endtask
  task automatic t_ctc();
    halt();
    wr(CMA, 16'h0003);
    wr(PRT, 16'h0004);
    wr(CTL, 16'h0114);
    cycles(8);
    high_count(1'b0, 16, h);
    check(16'(h), 16'h0008);
    rd(FLG, rv);
    check(16'(rv[1:0]), 16'h0002);
    halt();
    wr(CNT, 16'h0010);
    wr(CTL, 16'h0014);
    wait_flag(0, 70000, n);
    check(16'(n), 16'hFFF0);
    $display("t_ctc done");
  endtask
  task automatic t_tops();
    for (int i = 0; i < 5; i++)
    begin
      halt();
      wr(CAP, 16'h0040);
      wr(CTL, TCTL[i]);
      wait_flag(TFLG[i], 2000, n);
      check(16'(n), TTOP[i] + 16'h0001);
    end
    $display("t_tops done");
  endtask
  task automatic t_fpwm();
    halt();
    wr(CMA, 16'h0003);
    wr(CMB, 16'h0002);
    wr(PRT, 16'h0008);
    for (int pol = 2; pol <= 3; pol++)
    begin
      wr(CTL, 16'(pol << 10) | 16'h001F);
      cycles(8);
      high_count(1'b1, 16, h);
      check(16'(h), (pol == 2) ? 16'h0004 : 16'h000C);
    end
    wr(CMA, 16'h0007);
    cycles(16);
    high_count(1'b1, 16, h);
    check(16'(h), 16'h0006);
    rd(FLG, rv);
    check(16'(rv[2:0]), 16'h0007);
    // A TOP written below a stopped count must wait for the old TOP of 7, not run to MAX.
    wr(CTL, 16'h0C0F);
    wr(CNT, 16'h0005);
    wr(CMA, 16'h0003);
    wr(FLG, 16'h000F);
    wr(CTL, 16'h0C1F);
    wait_flag(0, 20, n);
    check(16'(n), 16'h0003);
    $display("t_fpwm done");
  endtask
  task automatic t_capture();
    for (int m = 0; m < 4; m++)
    begin
      wr(CTL, 16'(m << 8));
      wr(CNT, 16'h1234 + 16'(m));
      wr(FLG, 16'h000F);
      @(posedge ref_clk);
      capture_event <= 1'b1;
      @(posedge ref_clk);
      capture_event <= 1'b0;
      rd(CAP, rv);
      check(rv, 16'h1234 + 16'(m));
      check(16'(flags[3]), 16'h0001);
    end
    $display("t_capture done");
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_force();
    t_prescale();
    t_normal();
    t_ctc();
    t_tops();
    t_fpwm();
    t_capture();
    end_of_test();
  end
endmodule
`default_nettype wire
